// >>> pbm_regs.svh
// register offsets, field positions, reset values and bus codes of the bus master
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH
// ==========================================
// register byte offsets
`define PBM_ADDR_CTRL 12'h000
`define PBM_ADDR_CLS 12'h004
`define PBM_ADDR_TXMAX 12'h008
`define PBM_ADDR_RXMAX 12'h00C
`define PBM_ADDR_LAT 12'h010
`define PBM_ADDR_STAT 12'h014
// ==========================================
// control bits and register reset values
`define PBM_CTRL_MWI_CFG 0
`define PBM_CTRL_TERM_LINE 1
`define PBM_CTRL_RD_ALIGN 2
`define PBM_CTRL_PAR_RESP 3
`define PBM_CTRL_MWI_CMD 4
`define PBM_CTRL_RST 5'h00
`define PBM_CLS_RST 8'h00
`define PBM_MAX_RST 16'h0000
`define PBM_LAT_RST 8'h00
// ==========================================
// status bits, write one to clear
`define PBM_ST_DPD 8
`define PBM_ST_RTA 12
`define PBM_ST_DPE 15
`define PBM_ST_MASK 32'h0000_9100
`define PBM_ST_RST 32'h0000_0000
// ==========================================
// cache line and bus codes
`define PBM_CLS_8 8'h08
`define PBM_CLS_16 8'h10
`define PBM_MASK_8 4'h7
`define PBM_MASK_16 4'hF
`define PBM_CMD_MRM 4'hC
`define PBM_CMD_MRL 4'hE
`define PBM_CMD_MW 4'h7
`define PBM_CMD_MWI 4'hF
`define PBM_BE_ALL 4'h0
`define PBM_DSEL_WAIT 3'h5
`define PBM_RX_CHAN 2'h0
`endif

// >>> pbm_pkg.sv
// types shared by the bus master files
package pbm_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_REQ = 5'h02,
      ST_ADDR = 5'h04,
      ST_DATA = 5'h08,
      ST_TURN = 5'h10
   } pbm_state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic ctrl;
      logic [29:0] addr;
      logic [15:0] len;
      logic [15:0] level;
      logic [15:0] space;
   } pbm_chan_req_t;
   typedef struct packed {
      logic gntN;
      logic frameN;
      logic irdyN;
      logic trdyN;
      logic stopN;
      logic devselN;
      logic par;
      logic [31:0] ad;
   } pbm_pci_in_t;
   typedef struct packed {
      logic reqN;
      logic frameN;
      logic irdyN;
      logic perrN;
      logic par;
      logic ctlOe;
      logic adOe;
      logic perrOe;
      logic [3:0] cbeN;
      logic [31:0] ad;
   } pbm_pci_out_t;
   localparam pbm_pci_in_t PBM_IN_IDLE = '1;
   localparam pbm_pci_out_t PBM_OUT_IDLE = '{reqN: 1'b1, frameN: 1'b1, irdyN: 1'b1,
      perrN: 1'b1, par: 1'b0, ctlOe: 1'b0, adOe: 1'b0, perrOe: 1'b0, cbeN: 4'hF,
      ad: 32'h0000_0000};
endpackage : pbm_pkg

// >>> pbm_arb.sv
// round robin choice among the dma channels
`timescale 1ns/100ps
module pbm_arb #(
   parameter int unsigned NCH = 4,
   parameter int unsigned IW = 2
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [NCH-1:0] reqV,
   input wire logic take,
   output logic [IW-1:0] gntIdx,
   output logic gntValid
);
   logic [IW-1:0] last_q;
   logic [NCH-1:0] rot;
   logic [IW-1:0] idx [NCH];
   // ==========================================
   // rotate the requests behind the last winner
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_rot
         assign idx[gi] = IW'((int'(last_q) + 1 + gi) % NCH);
         assign rot[gi] = reqV[idx[gi]];
      end
   endgenerate
   always_comb begin
      gntIdx = idx[0];
      for (int i = NCH - 1; i >= 0; i--) begin
         if (rot[i]) begin
            gntIdx = idx[i];
         end
      end
   end
   assign gntValid = |reqV;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_q <= '0;
      end else if (take) begin
         last_q <= gntIdx;
      end
   end
endmodule : pbm_arb

// >>> pbm_initiator.sv
// pci bus master initiator for four dma channels, apb register slave
// ==========================================
`timescale 1ns/100ps
`include "pbm_regs.svh"
module pbm_initiator #(
   parameter int unsigned NCH = 4
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pbm_pkg::pbm_chan_req_t [NCH-1:0] chanReq,
   input wire logic [31:0] wrData,
   output logic dataPop,
   output logic [31:0] rdData,
   output logic rdValid,
   output logic [1:0] activeChan,
   output logic [NCH-1:0] chanDone,
   output logic chanAbort,
   input wire pbm_pkg::pbm_pci_in_t pciIn,
   output pbm_pkg::pbm_pci_out_t pciOut
);
   import pbm_pkg::*;
   // ==========================================
   // pin synchroniser
   pbm_pci_in_t s1_q;
   pbm_pci_in_t s_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= PBM_IN_IDLE;
         s_q <= PBM_IN_IDLE;
      end else begin
         s1_q <= pciIn;
         s_q <= s1_q;
      end
   end
   // ==========================================
   // registers
   logic [4:0] ctrl_q;
   logic [7:0] cls_q;
   logic [15:0] txMax_q;
   logic [15:0] rxMax_q;
   logic [7:0] latT_q;
   logic [31:0] status_q;
   logic [31:0] stSet;
   logic [31:0] prdata_q;
   logic [31:0] rdMux;
   pbm_state_t state_q;
   logic [1:0] chan_q;
   wire wrEn = psel & penable & pwrite;
   wire selCtrl = paddr == `PBM_ADDR_CTRL;
   wire selCls = paddr == `PBM_ADDR_CLS;
   wire selTx = paddr == `PBM_ADDR_TXMAX;
   wire selRx = paddr == `PBM_ADDR_RXMAX;
   wire selLat = paddr == `PBM_ADDR_LAT;
   wire selSt = paddr == `PBM_ADDR_STAT;
   wire mapped = selCtrl | selCls | selTx | selRx | selLat | selSt;
   wire busy = state_q != ST_IDLE;
   wire [31:0] stRead = status_q | {29'h0000_0000, chan_q, busy};
   assign rdMux = selCtrl ? {27'h0000_0000, ctrl_q} :
                  selCls ? {24'h0000_00, cls_q} :
                  selTx ? {16'h0000, txMax_q} :
                  selRx ? {16'h0000, rxMax_q} :
                  selLat ? {24'h0000_00, latT_q} :
                  selSt ? stRead : 32'h0000_0000;
   wire [31:0] stClr = (wrEn & selSt) ? (pwdata & `PBM_ST_MASK) : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `PBM_CTRL_RST;
         cls_q <= `PBM_CLS_RST;
         txMax_q <= `PBM_MAX_RST;
         rxMax_q <= `PBM_MAX_RST;
         latT_q <= `PBM_LAT_RST;
         status_q <= `PBM_ST_RST;
         prdata_q <= 32'h0000_0000;
      end else begin
         if (wrEn & selCtrl) ctrl_q <= pwdata[4:0];
         if (wrEn & selCls) cls_q <= pwdata[7:0];
         if (wrEn & selTx) txMax_q <= pwdata[15:0];
         if (wrEn & selRx) rxMax_q <= pwdata[15:0];
         if (wrEn & selLat) latT_q <= pwdata[7:0];
         // set wins over clear
         status_q <= (status_q & ~stClr) | stSet;
         if (psel & ~penable) prdata_q <= rdMux;
      end
   end
   // ==========================================
   // arbiter
   logic take;
   logic [1:0] gntIdx;
   logic gntValid;
   logic restart_q;
   logic [NCH-1:0] reqV;
   genvar gc;
   generate
      for (gc = 0; gc < NCH; gc++) begin : g_req
         assign reqV[gc] = chanReq[gc].valid & (state_q == ST_IDLE) & ~restart_q;
      end
   endgenerate
   pbm_arb #(.NCH(NCH), .IW(2)) u_arb (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .reqV(reqV),
      .take(take),
      .gntIdx(gntIdx),
      .gntValid(gntValid)
   );
   // ==========================================
   // burst decisions
   pbm_state_t state_d;
   logic [1:0] chan_d;
   logic [29:0] addr_q, addr_d;
   logic [15:0] rem_q, rem_d;
   logic [15:0] burst_q, burst_d;
   logic [7:0] lat_q, lat_d;
   logic [2:0] dsel_q, dsel_d;
   logic dselOk_q, dselOk_d;
   logic [3:0] cmd_q, cmd_d;
   logic restart_d;
   logic done;
   logic abort;
   logic tAbortSet;
   pbm_pci_out_t pciOut_q, pciOut_d;
   pbm_chan_req_t cur;
   assign cur = chanReq[chan_q];
   wire curWr = cur.write;
   wire [15:0] clsW = {8'h00, cls_q};
   wire cls16 = cls_q == `PBM_CLS_16;
   wire clsOk = cls16 | (cls_q == `PBM_CLS_8);
   wire [3:0] lineMask = cls16 ? `PBM_MASK_16 : `PBM_MASK_8;
   wire [29:0] addrNext = addr_q + 30'h0000_0001;
   wire lineEnd = (addrNext[3:0] & lineMask) == 4'h0;
   wire aligned = (addr_q[3:0] & lineMask) == 4'h0;
   wire isMwi = cmd_q == `PBM_CMD_MWI;
   wire mwiEn = ctrl_q[`PBM_CTRL_MWI_CFG] & ctrl_q[`PBM_CTRL_MWI_CMD];
   wire mwiStill = mwiEn & clsOk & (cur.level >= clsW) & (cur.space >= clsW);
   wire mwiOk = mwiStill & aligned & (chan_q == `PBM_RX_CHAN) & curWr & ~cur.ctrl
                & (rem_q >= clsW);
   wire [3:0] rdCmd = cur.ctrl ? `PBM_CMD_MRL : `PBM_CMD_MRM;
   wire [3:0] wrCmd = (mwiOk & ~cur.ctrl) ? `PBM_CMD_MWI : `PBM_CMD_MW;
   wire [3:0] cmdSel = curWr ? wrCmd : rdCmd;
   wire xfer = (state_q == ST_DATA) & ~s_q.trdyN & ~s_q.devselN;
   wire stopSeen = (state_q == ST_DATA) & ~s_q.stopN & ~s_q.devselN;
   wire tgtAbort = (state_q == ST_DATA) & ~s_q.stopN & s_q.devselN & dselOk_q;
   wire masterAbort = (state_q == ST_DATA) & ~dselOk_q & s_q.devselN
                      & (dsel_q == `PBM_DSEL_WAIT);
   wire latExp = lat_q >= latT_q;
   wire backoff = latExp & s_q.gntN;
   wire lastWord = rem_q == 16'h0001;
   wire [15:0] limit = curWr ? rxMax_q : txMax_q;
   wire limHit = (limit != 16'h0000) & ((burst_q + 16'h0001) >= limit);
   wire fifoEnd = cur.level <= 16'h0001;
   wire alignOn = ctrl_q[`PBM_CTRL_RD_ALIGN] & ~curWr;
   wire limEnd = limHit & (~alignOn | lineEnd);
   wire rdAlignEnd = alignOn & (cur.level <= clsW) & lineEnd;
   wire mwEnd = curWr & ~isMwi & ctrl_q[`PBM_CTRL_TERM_LINE] & lineEnd;
   wire otherEnd = backoff | fifoEnd | limEnd | rdAlignEnd | mwEnd;
   wire endNow = lastWord | (isMwi ? (lineEnd & (otherEnd | ~mwiStill)) : otherEnd);
   wire parResp = ctrl_q[`PBM_CTRL_PAR_RESP];
   wire parErr = xfer & ~curWr & ((^{s_q.ad, pciOut_q.cbeN}) != s_q.par);
   always_comb begin
      stSet = 32'h0000_0000;
      stSet[`PBM_ST_RTA] = tAbortSet;
      stSet[`PBM_ST_DPD] = parErr & parResp;
      stSet[`PBM_ST_DPE] = parErr;
   end
   // ==========================================
   // initiator state machine
   always_comb begin
      state_d = state_q;
      chan_d = chan_q;
      addr_d = addr_q;
      rem_d = rem_q;
      burst_d = burst_q;
      lat_d = lat_q;
      dsel_d = dsel_q;
      dselOk_d = dselOk_q;
      cmd_d = cmd_q;
      restart_d = restart_q;
      take = 1'b0;
      done = 1'b0;
      abort = 1'b0;
      tAbortSet = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (restart_q) begin
               state_d = ST_REQ;
            end else if (gntValid) begin
               take = 1'b1;
               chan_d = gntIdx;
               addr_d = chanReq[gntIdx].addr;
               rem_d = chanReq[gntIdx].len;
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            if (~s_q.gntN & s_q.frameN & s_q.irdyN) begin
               state_d = ST_ADDR;
               cmd_d = cmdSel;
               burst_d = 16'h0000;
               lat_d = 8'h00;
               dsel_d = 3'h0;
               dselOk_d = 1'b0;
               restart_d = 1'b0;
            end
         end
         ST_ADDR: begin
            state_d = ST_DATA;
         end
         ST_DATA: begin
            if (!latExp) lat_d = lat_q + 8'h01;
            if (!s_q.devselN) dselOk_d = 1'b1;
            if (dsel_q != `PBM_DSEL_WAIT) dsel_d = dsel_q + 3'h1;
            if (masterAbort) begin
               state_d = ST_TURN;
               abort = 1'b1;
            end else if (tgtAbort) begin
               state_d = ST_TURN;
               abort = 1'b1;
               tAbortSet = 1'b1;
            end else if (xfer) begin
               addr_d = addrNext;
               rem_d = rem_q - 16'h0001;
               burst_d = burst_q + 16'h0001;
               if (stopSeen | endNow) begin
                  state_d = ST_TURN;
                  done = lastWord;
                  restart_d = stopSeen & ~lastWord;
               end
            end else if (stopSeen) begin
               state_d = ST_TURN;
               restart_d = 1'b1;
            end
         end
         ST_TURN: begin
            state_d = ST_IDLE;
         end
      endcase
   end
   // ==========================================
   // pin drive
   wire inBurst = (state_d == ST_ADDR) | (state_d == ST_DATA);
   always_comb begin
      pciOut_d = pciOut_q;
      pciOut_d.reqN = state_d != ST_REQ;
      pciOut_d.frameN = ~inBurst;
      pciOut_d.irdyN = state_d != ST_DATA;
      pciOut_d.ctlOe = inBurst | (state_d == ST_TURN);
      pciOut_d.adOe = (state_d == ST_ADDR) | ((state_d == ST_DATA) & curWr);
      pciOut_d.cbeN = (state_d == ST_ADDR) ? cmd_d : `PBM_BE_ALL;
      if (state_d == ST_ADDR) begin
         pciOut_d.ad = {addr_d, 2'b00};
      end else if ((state_d == ST_DATA) & curWr) begin
         pciOut_d.ad = wrData;
      end
      pciOut_d.par = ^{pciOut_q.ad, pciOut_q.cbeN};
      pciOut_d.perrN = ~(parErr & parResp);
      pciOut_d.perrOe = parErr & parResp;
   end
   assign pciOut = pciOut_q;
   assign dataPop = xfer & curWr;
   assign activeChan = chan_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         chan_q <= 2'h0;
         addr_q <= 30'h0000_0000;
         rem_q <= 16'h0000;
         burst_q <= 16'h0000;
         lat_q <= 8'h00;
         dsel_q <= 3'h0;
         dselOk_q <= 1'b0;
         cmd_q <= `PBM_CMD_MW;
         restart_q <= 1'b0;
         pciOut_q <= PBM_OUT_IDLE;
      end else begin
         state_q <= state_d;
         chan_q <= chan_d;
         addr_q <= addr_d;
         rem_q <= rem_d;
         burst_q <= burst_d;
         lat_q <= lat_d;
         dsel_q <= dsel_d;
         dselOk_q <= dselOk_d;
         cmd_q <= cmd_d;
         restart_q <= restart_d;
         pciOut_q <= pciOut_d;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData <= 32'h0000_0000;
         rdValid <= 1'b0;
         chanDone <= '0;
         chanAbort <= 1'b0;
      end else begin
         rdValid <= xfer & ~curWr;
         if (xfer & ~curWr) rdData <= s_q.ad;
         chanDone <= done ? (NCH'(1) << chan_q) : '0;
         chanAbort <= abort;
      end
   end
   // ==========================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   chk_read_cmd: assert property ((state_q == ST_ADDR) && !curWr |->
      pciOut_q.cbeN == (cur.ctrl ? `PBM_CMD_MRL : `PBM_CMD_MRM))
      else $error("wrong read command");
   chk_ctl_write: assert property ((state_q == ST_ADDR) && curWr && cur.ctrl |->
      pciOut_q.cbeN == `PBM_CMD_MW)
      else $error("control write not plain write");
   chk_mwi_chan: assert property ((state_q == ST_ADDR) && (pciOut_q.cbeN == `PBM_CMD_MWI) |->
      (chan_q == `PBM_RX_CHAN) && ((pciOut_q.ad[5:2] & lineMask) == 4'h0))
      else $error("invalidate on wrong channel or address");
   chk_backoff_end: assert property (xfer && backoff && !isMwi && !tgtAbort |=>
      state_q == ST_TURN ##1 state_q == ST_IDLE)
      else $error("no back off");
   chk_tabort_flag: assert property (tgtAbort && !masterAbort |=>
      status_q[`PBM_ST_RTA] && !restart_q)
      else $error("target abort not flagged");
   chk_retry_again: assert property (stopSeen && !xfer && !tgtAbort && !masterAbort |=>
      restart_q ##2 state_q == ST_REQ)
      else $error("retry not restarted");
   chk_grant_wait: assert property ((state_q == ST_REQ) && s_q.gntN |=>
      pciOut_q.frameN && !pciOut_q.reqN)
      else $error("frame without grant");
   chk_line_term: assert property (xfer && curWr && !isMwi && mwEnd && !stopSeen |=>
      pciOut_q.frameN && (state_q == ST_TURN))
      else $error("no stop at line end");
   chk_perr_drive: assert property (parErr && parResp |=>
      !pciOut_q.perrN && status_q[`PBM_ST_DPD] && status_q[`PBM_ST_DPE])
      else $error("parity error not reported");
   chk_mwi_whole: assert property (xfer && isMwi && !lineEnd && !lastWord && !stopSeen |=>
      state_q == ST_DATA)
      else $error("invalidate cut inside a line");
   cov_mwi_burst: cover property ((state_q == ST_ADDR) && (pciOut_q.cbeN == `PBM_CMD_MWI));
   cov_retry: cover property (stopSeen && !xfer);
   cov_normal: cover property (xfer && lastWord ##1 state_q == ST_TURN);
   cov_master_abort: cover property (masterAbort);
endmodule : pbm_initiator

// >>> pbm_target_model.sv
// host memory target model facing the bus master pins
`timescale 1ns/100ps
module pbm_target_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] mode,
   input wire logic parBad,
   input wire pbm_pkg::pbm_pci_out_t pciOut,
   output pbm_pkg::pbm_pci_in_t pciIn,
   output logic [3:0] lastCmd,
   output logic [7:0] addrCnt,
   output logic beBad,
   output logic [31:0] firstWr
);
   import pbm_pkg::*;
   logic frameBus, irdyBus, frameQ, wrCyc, wrSeen, retried, gntNQ, trdyNQ, stopNQ, devselNQ;
   logic [31:0] adBus, adLast, rdAddr;
   // ==========================================
   // shared lines, control pulled up when released
   assign frameBus = pciOut.ctlOe ? pciOut.frameN : 1'b1;
   assign irdyBus = pciOut.ctlOe ? pciOut.irdyN : 1'b1;
   assign adBus = pciOut.adOe ? pciOut.ad : (!devselNQ && !wrCyc) ? rdAddr : ~adLast;
   // read parity stands with its data word, as the initiator compares it
   assign pciIn = '{gntN: gntNQ, frameN: frameBus, irdyN: irdyBus, trdyN: trdyNQ,
      stopN: stopNQ, devselN: devselNQ,
      par: pciOut.adOe ? pciOut.par : (^{adBus, pciOut.cbeN}) ^ parBad, ad: adBus};
   // ==========================================
   // mode 0 normal, 1 target abort, 2 no claim, 3 retry once
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {frameQ, gntNQ, trdyNQ, stopNQ, devselNQ, wrCyc} <= 6'h3F;
         {wrSeen, retried, beBad, addrCnt, lastCmd} <= '0;
         {adLast, rdAddr, firstWr} <= '0;
      end else begin
         frameQ <= frameBus;
         adLast <= adBus;
         gntNQ <= pciOut.reqN && frameBus && irdyBus;
         if (!frameBus && frameQ) begin
            addrCnt <= addrCnt + 8'h01;
            lastCmd <= pciOut.cbeN;
            wrCyc <= pciOut.cbeN[0];
            rdAddr <= pciOut.ad;
            {wrSeen, beBad} <= 2'b00;
         end
         if (!irdyBus) begin
            // target abort: claim first, then stop with the claim dropped
            devselNQ <= (mode == 2'd2) || (mode == 2'd1 && !devselNQ);
            stopNQ <= !((mode == 2'd1 && !devselNQ) || (mode == 2'd3 && !retried));
            trdyNQ <= (mode != 2'd0) && !(mode == 2'd3 && retried);
         end else begin
            {trdyNQ, stopNQ, devselNQ} <= 3'h7;
            if (mode == 2'd3 && !stopNQ) retried <= 1'b1;
         end
         if (mode == 2'd0) retried <= 1'b0;
         if (!irdyBus && !trdyNQ && !devselNQ) begin
            rdAddr <= rdAddr + 32'h0000_0004;
            beBad <= beBad | (pciOut.cbeN != 4'h0);
            wrSeen <= 1'b1;
            if (wrCyc && !wrSeen) firstWr <= adBus;
         end
      end
   end
endmodule : pbm_target_model

// >>> pci_bus_master_dma_initiator_tb.sv
// self-checking bench for the bus master initiator
`timescale 1ns/100ps
`include "pbm_regs.svh"
module pci_bus_master_dma_initiator_tb;
   import pbm_pkg::*;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, dataPop, rdValid, chanAbort;
   logic parBad, beBad, ab, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, wrData, rdData, firstRd, firstWr, r, wStart;
   logic [1:0] mode, activeChan;
   logic [3:0] chanDone, lastCmd;
   logic [7:0] addrCnt, aStart;
   pbm_chan_req_t [3:0] chanReq;
   pbm_pci_in_t pciIn;
   pbm_pci_out_t pciOut;
   int errorCnt, nCompared, rdCnt;
   pbm_initiator i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chanReq(chanReq), .wrData(wrData), .dataPop(dataPop), .rdData(rdData),
      .rdValid(rdValid), .activeChan(activeChan), .chanDone(chanDone), .chanAbort(chanAbort),
      .pciIn(pciIn), .pciOut(pciOut));
   pbm_target_model i_tgt (.core_clk(core_clk), .reset_n(reset_n), .mode(mode), .parBad(parBad),
      .pciOut(pciOut), .pciIn(pciIn), .lastCmd(lastCmd), .addrCnt(addrCnt), .beBad(beBad),
      .firstWr(firstWr));
   // ==========================================
   // clock, write source, read capture
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (dataPop === 1'b1) wrData <= wrData + 32'h0000_0001;
      // the channel follows its own progress, so a cut burst resumes with the rest
      if (dataPop === 1'b1 || rdValid === 1'b1) begin
         chanReq[activeChan].addr <= chanReq[activeChan].addr + 30'h0000_0001;
         chanReq[activeChan].len <= chanReq[activeChan].len - 16'h0001;
      end
      if (rdValid === 1'b1) begin
         if (rdCnt == 0) firstRd = rdData;
         rdCnt = rdCnt + 1;
      end
   end
   // ==========================================
   // tasks
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task xfer(input int ch, input logic wr, input logic ctl, input logic [29:0] a,
      input logic [15:0] n, input logic [15:0] lv, input logic [15:0] sp, input logic [1:0] md);
      int k;
      @(posedge core_clk);
      mode <= md;
      rdCnt = 0;
      aStart = addrCnt;
      wStart = wrData;
      chanReq[ch] <= '{valid: 1'b1, write: wr, ctrl: ctl, addr: a, len: n, level: lv, space: sp};
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (chanDone[ch] !== 1'b1 && chanAbort !== 1'b1 && k < 400);
      ab = chanAbort;
      chk("transfer end", 32'h1, 32'(k < 400));
      chanReq[ch].valid <= 1'b0;
      mode <= 2'd0;
      repeat (8) @(posedge core_clk);
   endtask : xfer
   task closeOut;
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : closeOut
   // ==========================================
   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      errorCnt++;
      closeOut;
   end
   // ==========================================
   // tests
   initial begin
      {psel, penable, pwrite, paddr, pwdata, parBad, mode, chanReq} = '0;
      {errorCnt, nCompared, rdCnt, wrData} = '0;
      reset_n = 1'b0;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0000_0000);
         chk("reset value", 32'h0000_0000, r);
      end
      apb(1'b1, 12'h018, 32'hFFFF_FFFF);
      chk("unmapped error", 32'h1, 32'(e));
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk("unmapped read", 32'h0, r);
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_001F);
      apb(1'b0, `PBM_ADDR_CTRL, 32'h0000_0000);
      chk("control", 32'h0000_001F, r);
      $display("test registers done");
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0000);
      xfer(1, 1'b0, 1'b0, 30'h0000_0040, 16'd4, 16'd64, 16'd64, 2'd0);
      chk("data read command", `PBM_CMD_MRM, lastCmd);
      chk("read words", 32'd4, 32'(rdCnt));
      chk("first read word", 32'h0000_0100, firstRd);
      chk("address phases", 32'd1, 32'(addrCnt - aStart));
      xfer(3, 1'b0, 1'b1, 30'h0000_0043, 16'd3, 16'd64, 16'd64, 2'd0);
      chk("control read command", `PBM_CMD_MRL, lastCmd);
      chk("control first word", 32'h0000_010C, firstRd);
      $display("test reads done");
      apb(1'b1, `PBM_ADDR_CLS, 32'(`PBM_CLS_8));
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0011);
      xfer(0, 1'b1, 1'b0, 30'h0000_0080, 16'd8, 16'd8, 16'd8, 2'd0);
      chk("invalidate command", `PBM_CMD_MWI, lastCmd);
      chk("byte enables", 32'h0, 32'(beBad));
      chk("first write word", wStart, firstWr);
      xfer(1, 1'b1, 1'b0, 30'h0000_0080, 16'd8, 16'd8, 16'd8, 2'd0);
      chk("non receive write command", `PBM_CMD_MW, lastCmd);
      xfer(2, 1'b1, 1'b1, 30'h0000_0080, 16'd8, 16'd8, 16'd8, 2'd0);
      chk("control write command", `PBM_CMD_MW, lastCmd);
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0001);
      xfer(0, 1'b1, 1'b0, 30'h0000_0080, 16'd8, 16'd8, 16'd8, 2'd0);
      chk("disabled invalidate command", `PBM_CMD_MW, lastCmd);
      $display("test writes done");
      xfer(0, 1'b0, 1'b0, 30'h0000_0020, 16'd2, 16'd64, 16'd64, 2'd1);
      chk("target abort", 32'h1, 32'(ab));
      chk("abort address phases", 32'd1, 32'(addrCnt - aStart));
      apb(1'b0, `PBM_ADDR_STAT, 32'h0000_0000);
      chk("abort status", 32'h0000_1000, r);
      apb(1'b1, `PBM_ADDR_STAT, 32'h0000_1000);
      apb(1'b0, `PBM_ADDR_STAT, 32'h0000_0000);
      chk("status cleared", 32'h0000_0000, r);
      xfer(0, 1'b0, 1'b0, 30'h0000_0020, 16'd2, 16'd64, 16'd64, 2'd2);
      chk("master abort", 32'h1, 32'(ab));
      chk("master abort phases", 32'd1, 32'(addrCnt - aStart));
      xfer(0, 1'b0, 1'b0, 30'h0000_0020, 16'd2, 16'd64, 16'd64, 2'd3);
      chk("retry phases", 32'd2, 32'(addrCnt - aStart));
      chk("retry words", 32'd2, 32'(rdCnt));
      $display("test terminations done");
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0008);
      parBad <= 1'b1;
      xfer(0, 1'b0, 1'b0, 30'h0000_0020, 16'd2, 16'd64, 16'd64, 2'd0);
      parBad <= 1'b0;
      apb(1'b0, `PBM_ADDR_STAT, 32'h0000_0000);
      chk("parity status", 32'h0000_8100, r);
      chk("parity words", 32'd2, 32'(rdCnt));
      $display("test parity done");
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0002);
      xfer(1, 1'b1, 1'b0, 30'h0000_0084, 16'd8, 16'd64, 16'd64, 2'd0);
      chk("line end bursts", 32'd2, 32'(addrCnt - aStart));
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0004);
      xfer(1, 1'b0, 1'b0, 30'h0000_0044, 16'd8, 16'd8, 16'd64, 2'd0);
      chk("align bursts", 32'd2, 32'(addrCnt - aStart));
      chk("align words", 32'd8, 32'(rdCnt));
      apb(1'b1, `PBM_ADDR_TXMAX, 32'h0000_0002);
      xfer(1, 1'b0, 1'b0, 30'h0000_0044, 16'd8, 16'd64, 16'd64, 2'd0);
      chk("aligned limit bursts", 32'd2, 32'(addrCnt - aStart));
      apb(1'b1, `PBM_ADDR_CTRL, 32'h0000_0000);
      xfer(1, 1'b0, 1'b0, 30'h0000_0040, 16'd4, 16'd64, 16'd64, 2'd0);
      chk("limit bursts", 32'd2, 32'(addrCnt - aStart));
      $display("test burst ends done");
      closeOut;
   end
endmodule : pci_bus_master_dma_initiator_tb
